// ===== common/temp_sched_pkg.sv
package temp_sched_pkg;
	// register byte addresses
	localparam logic [15:0] CFG_ADDR     = 16'h28a0;
	localparam logic [15:0] TRIG_ADDR    = 16'h28b4;
	// field positions in the configuration byte
	localparam int          PER_LSB      = 0;
	localparam int          BUSY_BIT     = 3;
	localparam int          SUPPLY_BIT   = 6;
	localparam int          BATSEL_BIT   = 7;
	// field position in the trigger byte
	localparam int          TRIG_BIT     = 6;
	// values after reset
	localparam logic [2:0]  PER_RST      = 3'h0;
	localparam logic        SUPPLY_RST   = 1'h0;
	localparam logic        BATSEL_RST   = 1'h0;
	localparam logic        TRIG_RST     = 1'h0;
	// period field codes
	localparam logic [2:0]  PER_OFF      = 3'h0;
	localparam logic [2:0]  PER_CONT     = 3'h7;
	localparam logic [3:0]  EXP_BASE     = 4'h3;
	// timing
	localparam int          CLK_HZ       = 25_000_000;
	localparam int          COMMIT_MS    = 6;
	localparam int          COMMIT_CYC   = COMMIT_MS * (CLK_HZ / 1000);
	localparam int          SEC_CYC      = CLK_HZ;
	// configuration byte contents
	typedef struct packed {
		logic       bat_sel;
		logic       supply_main;
		logic [2:0] period;
	} cfg_t;
	// measurement sequencer states
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_AUTO    = 2'b01,
		ST_ONESHOT = 2'b10
	} meas_state_t;
endpackage

// ===== design/commit_timer.sv
`timescale 1ns/1ns
`default_nettype none
module commit_timer import temp_sched_pkg::*; #(
	parameter int CYCLES = COMMIT_CYC
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// control
	input  wire logic load,
	output logic      busy
);
	////////////////////////////////////////////////////////////////////////
	logic [17:0] cnt_ff;   // cycles left in the commit

	// down counter, reloaded on an accepted write
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 18'h0;
		end else if (load) begin
			cnt_ff <= 18'(CYCLES);
		end else if (cnt_ff != 18'h0) begin
			cnt_ff <= cnt_ff - 18'h1;
		end
	end

	// busy while any cycle is left
	assign busy = (cnt_ff != 18'h0);
endmodule
`default_nettype wire

// ===== design/interval_timer.sv
`timescale 1ns/1ns
`default_nettype none
module interval_timer import temp_sched_pkg::*; #(
	parameter int SEC_CYCLES = SEC_CYC
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// period field
	input  wire logic [2:0] period,
	// one-cycle pulse at each interval end
	output logic            tick
);
	////////////////////////////////////////////////////////////////////////
	logic [24:0] pre_ff;   // cycles within the current second
	logic [9:0]  sec_ff;   // seconds within the interval
	logic        timed;    // period picks a timed interval
	logic        sec_end;  // last cycle of a second
	logic [9:0]  last_sec; // final second of the interval

	assign timed    = (period != PER_OFF) && (period != PER_CONT);
	assign sec_end  = (pre_ff == 25'(SEC_CYCLES - 1));
	assign last_sec = 10'((11'h1 << (EXP_BASE + 4'(period))) - 11'h1);
	assign tick     = timed && sec_end && (sec_ff == last_sec);

	// second prescaler and interval counter, idle unless timed
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pre_ff <= 25'h0;
			sec_ff <= 10'h0;
		end else if (!timed) begin
			pre_ff <= 25'h0;
			sec_ff <= 10'h0;
		end else if (sec_end) begin
			pre_ff <= 25'h0;
			sec_ff <= (sec_ff >= last_sec) ? 10'h0 : sec_ff + 10'h1;
		end else begin
			pre_ff <= pre_ff + 25'h1;
		end
	end
endmodule
`default_nettype wire

// ===== design/temp_measure_scheduler.sv
// Behaviour
// - period zero means no automatic measurements
// - one-shot trigger gives exactly one measurement; here only with period zero, else the bit stays set unused
// - hardware clears trigger when measurement finishes
// - trigger ignored in sleep and display modes; here the bit stays set and its measurement starts once the mode ends
// - supply select 1 main supply, 0 battery
// - sleep and display modes force sensor power
// - supply and trigger bits reset 0, read/write
// - battery select 1 main, 0 clock battery
// - busy during commit, writes blocked, up to 6 ms
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module temp_measure_scheduler import temp_sched_pkg::*; #(
	parameter int COMMIT_CYCLES = COMMIT_CYC,
	parameter int SEC_CYCLES    = SEC_CYC
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// apb slave
	input  wire logic [15:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// power mode
	input  wire logic        deep_sleep_mode,
	input  wire logic        display_only_mode,
	// sensor
	input  wire logic        meas_done,
	output logic             meas_start,
	output logic             sensor_power_on,
	output logic             sensor_supply_select,
	output logic             monitored_battery_select
);
	////////////////////////////////////////////////////////////////////////
	// declarations
	cfg_t        cfg_ff;          // configuration byte
	logic        trig_ff;         // one-shot trigger bit
	logic        pready_ff;       // access answer
	logic [31:0] prdata_ff;       // read data
	logic        pslverr_ff;      // unmapped access
	meas_state_t state_ff;        // sequencer state
	meas_state_t nxt_state;       // next sequencer state
	logic        auto_pend_ff;    // interval elapsed, start owed
	logic        start_ff;        // measurement start pulse
	logic        power_ff;        // sensor power
	logic        supply_ff;       // supply select out
	logic        batsel_ff;       // battery select out
	logic        access;          // apb access phase
	logic        xfer_done;       // completing edge
	logic        hit_cfg;         // address is config byte
	logic        hit_trig;        // address is trigger byte
	logic        wr_cfg;          // write to config byte
	logic        wr_trig;         // write to trigger byte
	logic        busy;            // config commit pending
	logic        tick;            // interval elapsed
	logic        low_power;       // sleep or display mode
	logic        start_auto;      // automatic start now
	logic        start_one;       // one-shot start now
	logic        trig_clear;      // one-shot finished

	assign access    = psel && penable;
	assign xfer_done = access && pready_ff;
	assign hit_cfg   = (paddr == CFG_ADDR);
	assign hit_trig  = (paddr == TRIG_ADDR);
	assign wr_cfg    = xfer_done && pwrite && hit_cfg;
	assign wr_trig   = xfer_done && pwrite && hit_trig;
	assign low_power = deep_sleep_mode || display_only_mode;

	////////////////////////////////////////////////////////////////////////
	// apb answer: one wait state, then registered data
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready_ff  <= 1'h0;
			pslverr_ff <= 1'h0;
		end else begin
			pready_ff  <= access && !pready_ff;
			pslverr_ff <= access && !pready_ff && !hit_cfg && !hit_trig;
		end
	end

	// read mux, loaded in the wait cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata_ff <= 32'h0;
		end else if (access && !pready_ff && !pwrite) begin
			prdata_ff <= 32'h0;
			if (hit_cfg) begin
				prdata_ff[PER_LSB +: 3]  <= cfg_ff.period;
				prdata_ff[BUSY_BIT]      <= busy;
				prdata_ff[SUPPLY_BIT]    <= cfg_ff.supply_main;
				prdata_ff[BATSEL_BIT]    <= cfg_ff.bat_sel;
			end
			if (hit_trig) begin
				prdata_ff[TRIG_BIT] <= trig_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration byte, locked while a commit is pending
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_ff.period      <= PER_RST;
			cfg_ff.supply_main <= SUPPLY_RST;
			cfg_ff.bat_sel     <= BATSEL_RST;
		end else if (wr_cfg && !busy) begin
			cfg_ff.period      <= pwdata[PER_LSB +: 3];
			cfg_ff.supply_main <= pwdata[SUPPLY_BIT];
			cfg_ff.bat_sel     <= pwdata[BATSEL_BIT];
		end
	end

	// commit timer for the config byte
	commit_timer #(
		.CYCLES (COMMIT_CYCLES)
	) u_commit (
		.mclk (mclk),
		.rst  (rst),
		.load (wr_cfg && !busy),
		.busy (busy)
	);

	// interval timer for automatic updates
	interval_timer #(
		.SEC_CYCLES (SEC_CYCLES)
	) u_interval (
		.mclk   (mclk),
		.rst    (rst),
		.period (cfg_ff.period),
		.tick   (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// one-shot trigger: a software write wins over the hardware clear
	assign trig_clear = (state_ff == ST_ONESHOT) && meas_done;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			trig_ff <= TRIG_RST;
		end else if (wr_trig) begin
			trig_ff <= pwdata[TRIG_BIT];
		end else if (trig_clear) begin
			trig_ff <= 1'h0;
		end
	end

	// an elapsed interval is owed until a start takes it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			auto_pend_ff <= 1'h0;
		end else if (cfg_ff.period == PER_OFF || cfg_ff.period == PER_CONT) begin
			auto_pend_ff <= 1'h0;
		end else if (tick) begin
			auto_pend_ff <= 1'h1;
		end else if (start_auto) begin
			auto_pend_ff <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// start conditions, only from idle
	always_comb begin
		start_auto = 1'h0;
		start_one  = 1'h0;
		if (state_ff == ST_IDLE) begin
			if (cfg_ff.period == PER_CONT) begin
				start_auto = 1'h1;
			end else if (cfg_ff.period != PER_OFF) begin
				start_auto = auto_pend_ff;
			end else begin
				start_one = trig_ff && !low_power;
			end
		end
	end

	// sequencer next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_auto) begin
					nxt_state = ST_AUTO;
				end else if (start_one) begin
					nxt_state = ST_ONESHOT;
				end
			end
			ST_AUTO, ST_ONESHOT: begin
				if (meas_done) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// sequencer state and start pulse
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			start_ff <= 1'h0;
		end else begin
			state_ff <= nxt_state;
			start_ff <= start_auto || start_one;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sensor power and supply routing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			power_ff  <= 1'h0;
			supply_ff <= 1'h0;
			batsel_ff <= 1'h0;
		end else begin
			power_ff  <= low_power || (nxt_state != ST_IDLE);
			supply_ff <= cfg_ff.supply_main && !low_power;
			batsel_ff <= cfg_ff.bat_sel;
		end
	end

	assign pready                   = pready_ff;
	assign prdata                   = prdata_ff;
	assign pslverr                  = pslverr_ff;
	assign meas_start               = start_ff;
	assign sensor_power_on          = power_ff;
	assign sensor_supply_select     = supply_ff;
	assign monitored_battery_select = batsel_ff;

	////////////////////////////////////////////////////////////////////////
	// assertions
	property p_no_auto;
		@(posedge mclk) disable iff (rst)
		(state_ff == ST_IDLE && cfg_ff.period == PER_OFF && !trig_ff) |=> !meas_start;
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("start with period zero");

	property p_continuous;
		@(posedge mclk) disable iff (rst)
		(state_ff == ST_IDLE && cfg_ff.period == PER_CONT) |=> meas_start && state_ff == ST_AUTO;
	endproperty
	a_continuous: assert property (p_continuous) else $error("continuous start missed");

	property p_single;
		@(posedge mclk) disable iff (rst)
		(meas_start && state_ff == ST_ONESHOT) |=> (!meas_start) [*2];
	endproperty
	a_single: assert property (p_single) else $error("one-shot started twice");

	property p_trig_clear;
		@(posedge mclk) disable iff (rst)
		(state_ff == ST_ONESHOT && meas_done && !wr_trig) |=> !trig_ff && state_ff == ST_IDLE;
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");

	property p_trig_ignored;
		@(posedge mclk) disable iff (rst)
		(state_ff == ST_IDLE && low_power && cfg_ff.period == PER_OFF) |=> !meas_start;
	endproperty
	a_trig_ignored: assert property (p_trig_ignored) else $error("start in low power");

	property p_supply;
		@(posedge mclk) disable iff (rst)
		!low_power |=> sensor_supply_select == $past(cfg_ff.supply_main);
	endproperty
	a_supply: assert property (p_supply) else $error("supply select wrong");

	property p_forced;
		@(posedge mclk) disable iff (rst)
		low_power |=> sensor_power_on && !sensor_supply_select;
	endproperty
	a_forced: assert property (p_forced) else $error("sensor not forced on");

	property p_readback;
		@(posedge mclk) disable iff (rst)
		(access && !pready_ff && !pwrite && hit_trig) |=> prdata[TRIG_BIT] == $past(trig_ff);
	endproperty
	a_readback: assert property (p_readback) else $error("trigger readback wrong");

	property p_batsel;
		@(posedge mclk) disable iff (rst)
		1'b1 |=> monitored_battery_select == $past(cfg_ff.bat_sel);
	endproperty
	a_batsel: assert property (p_batsel) else $error("battery select wrong");

	property p_locked;
		@(posedge mclk) disable iff (rst)
		(wr_cfg && busy) |=> $stable(cfg_ff);
	endproperty
	a_locked: assert property (p_locked) else $error("write during commit");

	property p_busy_set;
		@(posedge mclk) disable iff (rst)
		(wr_cfg && !busy) |=> busy [*4];
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not raised");
endmodule
`default_nettype wire

// ===== dv/test_temp_measure_scheduler.sv
`timescale 1ns/1ns
`default_nettype none
module test_temp_measure_scheduler import temp_sched_pkg::*;;
	localparam int SEC = 10; // shortened second
	////////////////////////////////////////////////////////////////////////
	// stimulus and observed signals
	logic        mclk, rst, psel, penable, pwrite;
	logic [15:0] paddr, ua;
	logic [31:0] pwdata, prdata, rd, d;
	logic        pready, pslverr, er, meas_done, meas_start;
	logic        deep_sleep_mode, display_only_mode;
	logic        sensor_power_on, sensor_supply_select, monitored_battery_select;
	logic [3:0]  dly = 4'h0; // sensor busy countdown
	int          error_cnt = 0, cmp_count = 0, start_cnt = 0, n, c0;
	temp_measure_scheduler #(.COMMIT_CYCLES(20), .SEC_CYCLES(SEC)) i_dut (
		.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .deep_sleep_mode(deep_sleep_mode),
		.display_only_mode(display_only_mode), .meas_done(meas_done),
		.meas_start(meas_start), .sensor_power_on(sensor_power_on),
		.sensor_supply_select(sensor_supply_select),
		.monitored_battery_select(monitored_battery_select));
	////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// sensor stand-in: finishes each measurement a few cycles after start
	always @(posedge mclk) begin
		meas_done <= (dly == 4'h1);
		if (meas_start === 1'b1) begin
			dly       <= 4'h3 + 4'($urandom_range(0, 4));
			start_cnt <= start_cnt + 1;
		end else if (dly != 4'h0)
			dly <= dly - 4'h1;
	end
	////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// one apb transfer, result left in rd and er
	task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] wd);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd      = prdata;
		er      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll the config byte until the commit is over
	task automatic idle_cfg();
		do begin
			apb(CFG_ADDR, 1'b0, 32'h0);
		end while (rd[BUSY_BIT] !== 1'b0);
	endtask
	// cycles until the next start pulse
	task automatic ws();
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (meas_start !== 1'b1);
	endtask
	function automatic logic [31:0] cfg_word(logic [2:0] p, logic s, logic b, logic bz);
		return {24'h0, b, s, 2'h0, bz, p};
	endfunction
	task automatic close_out();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#2400000;
		error_cnt++;
		close_out();
	end
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(89));
		{rst, psel, penable, pwrite, deep_sleep_mode, display_only_mode} = 6'h20;
		paddr  = 16'h0;
		pwdata = 32'h0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		apb(CFG_ADDR, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h0);
		apb(TRIG_ADDR, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk(32'(er), 32'h0);
		$display("test reset values done");
		// random selects, write during commit, unmapped places
		for (int i = 0; i < 6; i++) begin
			idle_cfg();
			d = $urandom & 32'hffff_fff8;
			apb(CFG_ADDR, 1'b1, d);
			apb(CFG_ADDR, 1'b0, 32'h0);
			chk(rd, cfg_word(3'h0, d[6], d[7], 1'b1));
			chk(32'(sensor_supply_select), 32'(d[6]));
			chk(32'(monitored_battery_select), 32'(d[7]));
			apb(CFG_ADDR, 1'b1, ~d & 32'hf8);
			apb(CFG_ADDR, 1'b0, 32'h0);
			chk(rd, cfg_word(3'h0, d[6], d[7], 1'b1));
			ua = 16'($urandom) & 16'hfffc;
			if (ua == CFG_ADDR || ua == TRIG_ADDR)
				ua = 16'h0;
			apb(ua, 1'(i), $urandom);
			chk(32'(er), 32'h1);
			if (i % 2 == 0)
				chk(rd, 32'h0);
		end
		$display("test selects done");
		// one-shot in normal, deep sleep and display-only modes
		for (int m = 0; m < 3; m++) begin
			idle_cfg();
			apb(CFG_ADDR, 1'b1, 32'h40);
			deep_sleep_mode   <= (m == 1);
			display_only_mode <= (m == 2);
			c0 = start_cnt;
			apb(TRIG_ADDR, 1'b1, 32'h40);
			if (m == 0) begin
				repeat (2) @(posedge mclk);
				chk(32'(sensor_power_on), 32'h1);
			end
			if (m != 0) begin
				apb(TRIG_ADDR, 1'b0, 32'h0);
				chk(rd, 32'h40);
				repeat (30) @(posedge mclk);
				chk(start_cnt, c0);
				chk(32'(sensor_power_on), 32'h1);
				chk(32'(sensor_supply_select), 32'h0);
				deep_sleep_mode   <= 1'b0;
				display_only_mode <= 1'b0;
			end
			repeat (20) @(posedge mclk);
			chk(start_cnt, c0 + 1);
			chk(32'(sensor_supply_select), 32'h1);
			chk(32'(sensor_power_on), 32'h0);
			apb(TRIG_ADDR, 1'b0, 32'h0);
			chk(rd, 32'h0);
		end
		$display("test one-shot done");
		// every automatic period code
		for (int p = 1; p < 8; p++) begin
			idle_cfg();
			apb(CFG_ADDR, 1'b1, 32'(p));
			ws();
			ws();
			if (p < 7)
				chk(n, (1 << (3 + p)) * SEC);
			else
				chk(32'(n <= 14), 32'h1);
		end
		$display("test periods done");
		// period zero stops automatic work
		idle_cfg();
		apb(CFG_ADDR, 1'b1, 32'h0);
		repeat (20) @(posedge mclk);
		c0 = start_cnt;
		repeat (2000) @(posedge mclk);
		chk(start_cnt, c0);
		$display("test period zero done");
		close_out();
	end
endmodule
`default_nettype wire
